// File: hdl/link_ctrl_params.svh
// Purpose: register indices, field positions, reset values and widths of the link control bank
// Assumes: included by its bare name from every file that needs it
// Notes:   byte address of a register is its index times four
`ifndef LINK_CTRL_PARAMS_SVH
`define LINK_CTRL_PARAMS_SVH

// register indices; byte address is {index, 2'h0}
`define STEER_IDX      10'h09B
`define DITHER_IDX     10'h09D
`define MARKER_IDX     10'h160
`define LINK_IDX       10'h200
`define STATUS_IDX     10'h20F

// field widths and positions
`define STEER_W        5
`define STEER_MAX      5'h1F
`define DITHER_ON_BIT  0
`define DITHER_AMP_BIT 1
`define DITHER_ERR_BIT 2
`define MARKER_ON_BIT  0
`define LINK_ON_BIT    0
`define STAT_MARK_BIT  0
`define STAT_SWAP_BIT  1
`define STAT_RST_BIT   2

// reset values
`define STEER_RESET    5'h07
`define DITHER_RESET   3'h0
`define MARKER_RESET   1'h0
`define LINK_RESET     1'h1
`define ILA_CS_ZERO    2'h0

`endif

// File: hdl/link_ctrl_pkg.sv
// Purpose: shared types of the link control bank
// Assumes: constants live in link_ctrl_params.svh
// Notes:   nothing here is imported; users write link_ctrl_pkg::name
package link_ctrl_pkg;

  // which register an address selects
  typedef enum logic [2:0] {
    REG_NONE,
    REG_STEER,
    REG_DITHER,
    REG_MARKER,
    REG_LINK,
    REG_STATUS
  } reg_sel_t;

  typedef logic [7:0] reg_byte_t;

endpackage

// File: hdl/select_delay_line.sv
// Purpose: programmable delay of the core steering select during swaps
// Assumes: select and swap flag come from logic on clk_sys
// Notes:   output is registered; delay d adds d cycles on top of one
`timescale 1ns/100ps
`include "link_ctrl_params.svh"
module select_delay_line #(
  parameter int DEPTH = 32
) (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                sel_in,
  input  wire logic                swap_active,
  input  wire logic [`STEER_W-1:0] delay,
  output logic                     sel_out
);

  logic [DEPTH-1:0] hist;
  logic [DEPTH-1:0] next_hist;
  logic             next_sel_out;

  // history of the select; the tap is chosen only while a swap runs
  always_comb begin
    next_hist = {hist[DEPTH-2:0], sel_in};
    if (swap_active && (delay != '0)) begin // [R3]
      next_sel_out = hist[delay - `STEER_W'(1)]; // [R1] [R2]
    end else begin
      next_sel_out = sel_in;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hist    <= '0;
      sel_out <= 1'b0;
    end else begin
      hist    <= next_hist;
      sel_out <= next_sel_out;
    end
  end

endmodule // select_delay_line

// File: hdl/adc_swap_dither_link_ctrl.sv
// Purpose: configuration slice for core swap steering, dither, sample marker and link enable
// Assumes: APB slave on clk_sys; marker_pin is asynchronous, all other inputs are on clk_sys
// Notes:   zero-wait APB answer; reserved bits read as zero and ignore writes
`timescale 1ns/100ps
`include "link_ctrl_params.svh"

// How it works
// [R1] the steering select is delayed by a five-bit field that resets to seven.
// [R2] every delay value from zero to thirty-one is accepted and used.
// [R3] the delay acts only while a core swap runs; otherwise the select passes straight on.
// [R4] software tunes the delay so the swap lands where both sample streams are valid.
// [R5] software writes reserved bits only as zero.
// [R6] dither bit 0 turns dither on, and it resets off.
// [R7] dither bit 1 picks small (0) or large (1) dither amplitude.
// [R8] dither bit 2 sends the rounding error into noise (0) or offset and spurs (1).
// [R9] with marker bit 0 set, each output sample carries the marker input in its lowest bit.
// [R10] the marker sees the same latency through the block as the sample data.
// [R11] in a wider link field the marker takes the lowest padding bit and keeps the sample.
// [R12] the control-bit count announced in lane alignment stays zero.
// [R13] software turns on the marker input receiver together with marker insertion.
// [R14] link bit 0 resets to one; at zero the link is held in reset, powered down and gated.
// [R15] while the link is off the multiframe counter is held in reset.
// [R16] software clears link enable before changing other link settings.
// [R17] calibration is enabled before the link and disabled after it.
module adc_swap_dither_link_ctrl #(
  parameter int ADC_W  = 12,
  parameter int LINK_W = 16
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              steer_sel_in,
  input  wire logic              swap_active,
  output logic                   steer_sel_out,
  output logic                   dither_on,
  output logic                   dither_amplitude_sel,
  output logic                   dither_rounding_choice,
  input  wire logic [ADC_W-1:0]  adc_sample,
  input  wire logic              adc_sample_valid,
  input  wire logic              marker_pin,
  output logic      [LINK_W-1:0] link_sample,
  output logic                   link_sample_valid,
  output logic      [1:0]        ila_cs_count,
  output logic                   link_reset,
  output logic                   serializer_power_down,
  output logic                   link_clock_enable,
  output logic                   lmfc_counter_reset
);

  // reset image of the dither register; each field picks its own bit from it
  localparam logic [2:0] DITHER_RST = `DITHER_RESET;

  // register state
  logic [`STEER_W-1:0]        swap_steering_delay;
  logic                       marker_insert_on;
  logic                       serial_link_on;
  logic [`STEER_W-1:0]        next_swap_steering_delay;
  logic                       next_dither_on;
  logic                       next_dither_amplitude_sel;
  logic                       next_dither_rounding_choice;
  logic                       next_marker_insert_on;
  logic                       next_serial_link_on;
  logic [31:0]                next_prdata;
  logic                       next_pready;
  logic                       next_pslverr;
  link_ctrl_pkg::reg_sel_t    sel;
  link_ctrl_pkg::reg_byte_t   rd_byte;
  logic                       wr_fire;

  // data path state
  logic                       marker_s1;
  logic                       marker_s2;
  logic [ADC_W-1:0]           samp_d1;
  logic [ADC_W-1:0]           samp_d2;
  logic                       valid_d1;
  logic                       valid_d2;
  logic [LINK_W-1:0]          next_link_sample;
  logic                       next_link_sample_valid;

  // address decode of an aligned word
  function automatic link_ctrl_pkg::reg_sel_t addr_decode(input logic [11:0] a);
    case (a)
      {`STEER_IDX, 2'h0}:  addr_decode = link_ctrl_pkg::REG_STEER;
      {`DITHER_IDX, 2'h0}: addr_decode = link_ctrl_pkg::REG_DITHER;
      {`MARKER_IDX, 2'h0}: addr_decode = link_ctrl_pkg::REG_MARKER;
      {`LINK_IDX, 2'h0}:   addr_decode = link_ctrl_pkg::REG_LINK;
      {`STATUS_IDX, 2'h0}: addr_decode = link_ctrl_pkg::REG_STATUS;
      default:             addr_decode = link_ctrl_pkg::REG_NONE;
    endcase
  endfunction

  assign sel     = addr_decode(paddr);
  assign wr_fire = psel && penable && pready && pwrite && pstrb[0];

  // read value of the selected register; reserved bits read zero
  always_comb begin
    rd_byte = '0;
    case (sel)
      link_ctrl_pkg::REG_STEER:  rd_byte[`STEER_W-1:0] = swap_steering_delay;
      link_ctrl_pkg::REG_DITHER: begin
        rd_byte[`DITHER_ON_BIT]  = dither_on;
        rd_byte[`DITHER_AMP_BIT] = dither_amplitude_sel;
        rd_byte[`DITHER_ERR_BIT] = dither_rounding_choice;
      end
      link_ctrl_pkg::REG_MARKER: rd_byte[`MARKER_ON_BIT] = marker_insert_on;
      link_ctrl_pkg::REG_LINK:   rd_byte[`LINK_ON_BIT] = serial_link_on;
      link_ctrl_pkg::REG_STATUS: begin
        rd_byte[`STAT_MARK_BIT] = marker_s2;
        rd_byte[`STAT_SWAP_BIT] = swap_active;
        rd_byte[`STAT_RST_BIT]  = link_reset;
      end
      default: rd_byte = '0;
    endcase
  end

  // bus answer and register writes; reserved bits are dropped on write
  always_comb begin
    next_pready                 = psel && !penable;
    next_pslverr                = psel && !penable && (sel == link_ctrl_pkg::REG_NONE);
    next_prdata                 = prdata;
    next_swap_steering_delay    = swap_steering_delay;
    next_dither_on              = dither_on;
    next_dither_amplitude_sel   = dither_amplitude_sel;
    next_dither_rounding_choice = dither_rounding_choice;
    next_marker_insert_on       = marker_insert_on;
    next_serial_link_on         = serial_link_on;
    if (psel && !penable) begin
      next_prdata = {24'h0, rd_byte};
    end
    if (wr_fire) begin
      case (sel)
        link_ctrl_pkg::REG_STEER:  next_swap_steering_delay = pwdata[`STEER_W-1:0]; // [R2]
        link_ctrl_pkg::REG_DITHER: begin
          next_dither_on              = pwdata[`DITHER_ON_BIT];  // [R6]
          next_dither_amplitude_sel   = pwdata[`DITHER_AMP_BIT]; // [R7]
          next_dither_rounding_choice = pwdata[`DITHER_ERR_BIT]; // [R8]
        end
        link_ctrl_pkg::REG_MARKER: next_marker_insert_on = pwdata[`MARKER_ON_BIT]; // [R9]
        link_ctrl_pkg::REG_LINK:   next_serial_link_on = pwdata[`LINK_ON_BIT]; // [R14]
        default:                   next_serial_link_on = serial_link_on;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata                 <= 32'h0;
      pready                 <= 1'b0;
      pslverr                <= 1'b0;
      swap_steering_delay    <= `STEER_RESET; // [R1]
      dither_on              <= DITHER_RST[`DITHER_ON_BIT]; // [R6]
      dither_amplitude_sel   <= DITHER_RST[`DITHER_AMP_BIT]; // [R7]
      dither_rounding_choice <= DITHER_RST[`DITHER_ERR_BIT]; // [R8]
      marker_insert_on       <= `MARKER_RESET;
      serial_link_on         <= `LINK_RESET; // [R14]
    end else begin
      prdata                 <= next_prdata;
      pready                 <= next_pready;
      pslverr                <= next_pslverr;
      swap_steering_delay    <= next_swap_steering_delay;
      dither_on              <= next_dither_on;
      dither_amplitude_sel   <= next_dither_amplitude_sel;
      dither_rounding_choice <= next_dither_rounding_choice;
      marker_insert_on       <= next_marker_insert_on;
      serial_link_on         <= next_serial_link_on;
    end
  end

  // steering select delay line
  select_delay_line #(
    .DEPTH       (32)
  ) u_steer_delay (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .sel_in      (steer_sel_in),
    .swap_active (swap_active),
    .delay       (swap_steering_delay),
    .sel_out     (steer_sel_out)
  );

  // output sample: sample in the top bits, marker in bit 0, zero while link is off
  always_comb begin
    next_link_sample       = '0;
    next_link_sample_valid = 1'b0;
    if (serial_link_on) begin // [R14]
      next_link_sample[LINK_W-1 -: ADC_W] = samp_d2; // [R11]
      if (marker_insert_on) begin
        next_link_sample[0] = marker_s2; // [R9] [R11]
      end
      next_link_sample_valid = valid_d2;
    end
  end

  // marker synchroniser and matching two-stage sample delay
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      marker_s1         <= 1'b0;
      marker_s2         <= 1'b0;
      samp_d1           <= '0;
      samp_d2           <= '0;
      valid_d1          <= 1'b0;
      valid_d2          <= 1'b0;
      link_sample       <= '0;
      link_sample_valid <= 1'b0;
    end else begin
      marker_s1         <= marker_pin;
      marker_s2         <= marker_s1;
      samp_d1           <= adc_sample; // [R10]
      samp_d2           <= samp_d1; // [R10]
      valid_d1          <= adc_sample_valid;
      valid_d2          <= valid_d1;
      link_sample       <= next_link_sample;
      link_sample_valid <= next_link_sample_valid;
    end
  end

  // link subsystem controls follow the enable bit; the control-bit count stays zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ila_cs_count          <= `ILA_CS_ZERO;
      link_reset            <= ~`LINK_RESET;
      serializer_power_down <= ~`LINK_RESET;
      link_clock_enable     <= `LINK_RESET;
      lmfc_counter_reset    <= ~`LINK_RESET;
    end else begin
      ila_cs_count          <= `ILA_CS_ZERO; // [R12]
      link_reset            <= !serial_link_on; // [R14]
      serializer_power_down <= !serial_link_on; // [R14]
      link_clock_enable     <= serial_link_on; // [R14]
      lmfc_counter_reset    <= !serial_link_on; // [R15]
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_delay_reset_val: assert property ( // [R1]
    $fell(rst) |-> swap_steering_delay == `STEER_RESET)
    else $error("steering delay not seven after reset");

  chk_delay_full_range: assert property ( // [R2]
    wr_fire && sel == link_ctrl_pkg::REG_STEER && pwdata[`STEER_W-1:0] == `STEER_MAX
    |=> swap_steering_delay == `STEER_MAX)
    else $error("delay of thirty-one not accepted");

  chk_steer_no_swap: assert property ( // [R3]
    !swap_active |=> steer_sel_out == $past(steer_sel_in))
    else $error("select delayed outside a swap");

  chk_steer_swap_tap: assert property ( // [R1]
    swap_active && swap_steering_delay == 5'h03 |=> steer_sel_out == $past(steer_sel_in, 4))
    else $error("select not delayed by programmed amount in a swap");

  chk_dither_write: assert property ( // [R6] [R7] [R8]
    wr_fire && sel == link_ctrl_pkg::REG_DITHER
    |=> {dither_rounding_choice, dither_amplitude_sel, dither_on} == $past(pwdata[2:0]))
    else $error("dither controls do not follow the write");

  chk_marker_lsb_time: assert property ( // [R9] [R10]
    serial_link_on && marker_insert_on |=> link_sample[0] == $past(marker_pin, 3))
    else $error("marker bit wrong or misaligned");

  chk_sample_kept: assert property ( // [R11] [R10]
    (LINK_W > ADC_W) && serial_link_on
    |=> link_sample[LINK_W-1 -: ADC_W] == $past(adc_sample, 3))
    else $error("sample bits disturbed by marker");

  chk_ila_cs_zero: assert property ( // [R12]
    ila_cs_count == `ILA_CS_ZERO)
    else $error("control bit announced in alignment");

  chk_link_held_off: assert property ( // [R14] [R15]
    !serial_link_on |=> link_reset && serializer_power_down && !link_clock_enable
                        && lmfc_counter_reset && !link_sample_valid)
    else $error("link not held while disabled");

  chk_link_released: assert property ( // [R14]
    serial_link_on |=> !link_reset && !serializer_power_down && link_clock_enable
                       && !lmfc_counter_reset)
    else $error("link still held while enabled");

  chk_marker_off_lsb: assert property ( // [R9] [R11]
    (LINK_W > ADC_W) && serial_link_on && !marker_insert_on |=> link_sample[0] == 1'b0)
    else $error("marker bit sent while insertion is off");

  chk_delay_tap_max: assert property ( // [R2]
    swap_active && swap_steering_delay == `STEER_MAX
    |=> steer_sel_out == $past(steer_sel_in, 32))
    else $error("select not delayed by the largest amount in a swap");

  cov_swap_delayed:  cover property (swap_active && swap_steering_delay != 5'h00);
  cov_steer_max:     cover property (swap_active && swap_steering_delay == `STEER_MAX);
  cov_marker_sent:   cover property (link_sample_valid && marker_insert_on && link_sample[0]);
  cov_link_off:      cover property ($fell(serial_link_on));
  cov_unmapped:      cover property (pready && pslverr);

endmodule // adc_swap_dither_link_ctrl

// File: bench/tb_adc_swap_dither_link_ctrl.sv
// Purpose: self-checking bench for the swap steering, dither, marker and link enable bank
// Assumes: zero-wait APB slave on clk_sys; default widths ADC_W 12, LINK_W 16
// Notes:   only mismatches and the verdict are printed
`timescale 1ns/100ps
`include "link_ctrl_params.svh"
module tb_adc_swap_dither_link_ctrl;
  localparam logic [11:0] A_STEER  = {`STEER_IDX, 2'h0};
  localparam logic [11:0] A_DITHER = {`DITHER_IDX, 2'h0};
  localparam logic [11:0] A_MARKER = {`MARKER_IDX, 2'h0};
  localparam logic [11:0] A_LINK   = {`LINK_IDX, 2'h0};
  localparam logic [11:0] A_STATUS = {`STATUS_IDX, 2'h0};

  logic        clk_sys;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        steer_sel_in;
  logic        swap_active;
  logic        steer_sel_out;
  logic        dither_on;
  logic        dither_amplitude_sel;
  logic        dither_rounding_choice;
  logic [11:0] adc_sample;
  logic        adc_sample_valid;
  logic        marker_pin;
  logic [15:0] link_sample;
  logic        link_sample_valid;
  logic [1:0]  ila_cs_count;
  logic        link_reset;
  logic        serializer_power_down;
  logic        link_clock_enable;
  logic        lmfc_counter_reset;
  logic [31:0] rdata;
  logic        rerr;
  int          n_fail;
  int          checks;

  // free-running system clock
  always #4 clk_sys = ~clk_sys;

  adc_swap_dither_link_ctrl DUT (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .steer_sel_in(steer_sel_in), .swap_active(swap_active),
    .steer_sel_out(steer_sel_out), .dither_on(dither_on),
    .dither_amplitude_sel(dither_amplitude_sel),
    .dither_rounding_choice(dither_rounding_choice), .adc_sample(adc_sample),
    .adc_sample_valid(adc_sample_valid), .marker_pin(marker_pin),
    .link_sample(link_sample), .link_sample_valid(link_sample_valid),
    .ila_cs_count(ila_cs_count), .link_reset(link_reset),
    .serializer_power_down(serializer_power_down),
    .link_clock_enable(link_clock_enable), .lmfc_counter_reset(lmfc_counter_reset)
  );

  // verdict and end of run
  task finish_test();
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // compare seen against expected
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one APB transfer; holds the request until pready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) n_fail++;
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk({31'h0, rerr}, 32'h0);
    chk(rdata, exp);
  endtask

  // let a few edges pass and sample just after the last one
  task wait_n(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // select edge goes through the delay only while a swap runs
  task steer_run(input int d, input logic sw);
    int          k;
    logic [31:0] exp;
    wr(A_STEER, 32'(d));
    swap_active  <= sw;
    steer_sel_in <= 1'b0;
    repeat (40) @(posedge clk_sys);
    steer_sel_in <= 1'b1;
    for (k = 1; k <= d + 2; k++) begin
      @(posedge clk_sys);
      #1;
      exp = 32'(k >= (sw ? d : 0) + 1);
      chk({31'h0, steer_sel_out}, exp);
    end
  endtask

  // two samples back to back; marker rides in bit 0 of the padded field
  task sample_run(input logic on);
    wr(A_MARKER, {31'h0, on});
    @(posedge clk_sys);
    adc_sample <= 12'hA5C;
    marker_pin <= 1'b1;
    @(posedge clk_sys);
    adc_sample <= 12'h3F1;
    marker_pin <= 1'b0;
    wait_n(2);
    chk({16'h0, link_sample}, {16'h0, 12'hA5C, 3'h0, on});
    chk({30'h0, ila_cs_count}, 32'h0);
    wait_n(1);
    chk({16'h0, link_sample}, {16'h0, 12'h3F1, 4'h0});
    chk({31'h0, link_sample_valid}, 32'h1);
  endtask

  // watchdog against a hung handshake
  initial begin
    #40000;
    n_fail++;
    finish_test();
  end

  // main sequence
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    steer_sel_in = 1'b0;
    swap_active = 1'b0;
    adc_sample = 12'h000;
    adc_sample_valid = 1'b1;
    marker_pin = 1'b0;
    n_fail = 0;
    checks = 0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    // reset values of the register table
    rd_chk(A_STEER, 32'h07);
    rd_chk(A_DITHER, 32'h00);
    rd_chk(A_MARKER, 32'h00);
    rd_chk(A_LINK, 32'h01);
    chk({28'h0, link_reset, serializer_power_down, link_clock_enable, lmfc_counter_reset},
        32'h2);
    // full range of the delay field in a swap, and a delay of 3 without a swap
    wr(A_STEER, 32'h1F);
    rd_chk(A_STEER, 32'h1F);
    steer_run(0, 1'b1);
    steer_run(3, 1'b1);
    steer_run(31, 1'b1);
    steer_run(3, 1'b0);
    // every combination of the three dither bits
    for (int i = 0; i < 8; i++) begin
      wr(A_DITHER, 32'(i));
      wait_n(2);
      chk({29'h0, dither_rounding_choice, dither_amplitude_sel, dither_on}, 32'(i));
      rd_chk(A_DITHER, 32'(i));
    end
    sample_run(1'b0);
    sample_run(1'b1);
    // link off holds reset, power-down, clock gate and counter reset
    wr(A_LINK, 32'h0);
    wait_n(3);
    chk({27'h0, link_reset, serializer_power_down, link_clock_enable, lmfc_counter_reset,
         link_sample_valid}, 32'h1A);
    chk({16'h0, link_sample}, 32'h0);
    rd_chk(A_STATUS, 32'h4);
    wr(A_LINK, 32'h1);
    wait_n(3);
    chk({27'h0, link_reset, serializer_power_down, link_clock_enable, lmfc_counter_reset,
         link_sample_valid}, 32'h05);
    // unmapped word answers with an error and zero data
    apb(1'b0, 12'h004, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdata, 32'h0);
    finish_test();
  end
endmodule // tb_adc_swap_dither_link_ctrl
